//--- inc/ssa_pkg.sv
// shared constants and types for the step attenuator control block
package ssa_pkg;

   // ************************************************************
   // link sampling and word layout
   // ************************************************************
   localparam int SYNC_STAGES = 2;
   localparam int WORD_W = 8;
   localparam int ATTEN_W = 7;
   localparam int PIN_W = 4 + ATTEN_W;
   // wait after reset until synchronised pins are trustworthy
   localparam int INIT_WAIT = SYNC_STAGES + 1;
   localparam logic [1:0] INIT_LAST = 2'(INIT_WAIT - 1);

   // positions inside the synchronised pin vector
   localparam int PIN_SCLK = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_STROBE = 2;
   localparam int PIN_SEL = 3;
   localparam int PIN_PAR_LSB = 4;

   // ************************************************************
   // register map, byte addresses on the avalon slave
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_SHIFT = 4'h8;
   localparam int CTRL_FREEZE_BIT = 0;
   localparam int STAT_ATTEN_LSB = 0;
   localparam int STAT_MODE_BIT = 8;
   localparam int STAT_STROBE_BIT = 9;
   localparam int STAT_RUN_BIT = 10;
   localparam logic CTRL_FREEZE_RST = 1'b0;

   // ************************************************************
   // enumerations
   // ************************************************************
   typedef enum logic [0:0] {
      SSA_ST_INIT = 1'b0,
      SSA_ST_RUN = 1'b1
   } ssa_state_t;

   typedef enum logic [1:0] {
      SSA_REG_CTRL = 2'b00,
      SSA_REG_STATUS = 2'b01,
      SSA_REG_SHIFT = 2'b10,
      SSA_REG_NONE = 2'b11
   } ssa_reg_t;

endpackage

//--- hw/ssa_sync.sv
// two-stage synchroniser for the control pins of the attenuator
`timescale 1ns/100ps
module ssa_sync
#(
   parameter int WIDTH = ssa_pkg::PIN_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ssa_sync_state_t;

   ssa_sync_state_t r_q;
   ssa_sync_state_t r_d;

   // refuse a vector the pipeline cannot carry
   if (WIDTH < 1)
   begin : g_bad_width
      $error("ssa_sync: WIDTH must be at least one");
   end

   // first stage feeds only the second stage
   always_comb
   begin
      r_d = r_q;
      r_d.meta = d_i;
      r_d.stable = r_q.meta;
   end

   // reset to zero: strobe reads low until pins settle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_q <= '0;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign q_o = r_q.stable;

endmodule

//--- hw/ssa_ctrl.sv
// control logic of the 7-bit step attenuator: serial, latched and direct parallel loading
`timescale 1ns/100ps

module ssa_ctrl
#(
   parameter int WORD_W = ssa_pkg::WORD_W,
   parameter int ATTEN_W = ssa_pkg::ATTEN_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_i,
   input wire logic latch_strobe_i,
   input wire logic parallel_serial_select_i,
   input wire logic atten_bit_quarter_db_i,
   input wire logic atten_bit_half_db_i,
   input wire logic atten_bit_one_db_i,
   input wire logic atten_bit_two_db_i,
   input wire logic atten_bit_four_db_i,
   input wire logic atten_bit_eight_db_i,
   input wire logic atten_bit_sixteen_db_i,
   input wire logic [ssa_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [ssa_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [ssa_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [ATTEN_W-1:0] atten_state_o
);

   // all steps switched in is the maximum attenuation
   localparam logic [ATTEN_W-1:0] ATTEN_FULL = {ATTEN_W{1'b1}};

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (WORD_W <= ATTEN_W || ATTEN_W != ssa_pkg::ATTEN_W)
   begin : g_bad_width
      $error("ssa_ctrl: word must exceed the attenuation width, which must match the pins");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      ssa_pkg::ssa_state_t state;
      logic [1:0] init_cnt;
      logic [WORD_W-1:0] shift;
      logic [ATTEN_W-1:0] atten;
      logic sclk_prev;
      logic strobe_prev;
      logic freeze;
      logic waitreq;
      logic [ssa_pkg::DATA_W-1:0] rdata;
   } ssa_ctrl_state_t;

   ssa_ctrl_state_t r_q;
   ssa_ctrl_state_t r_d;

   logic [ssa_pkg::PIN_W-1:0] pins_raw;
   logic [ssa_pkg::PIN_W-1:0] pins_s;
   logic s_sclk;
   logic s_sdata;
   logic s_strobe;
   logic s_sel;
   logic [ATTEN_W-1:0] s_par;
   logic ser_rise;
   logic strobe_rise;
   logic [ssa_pkg::DATA_W-1:0] read_mux;
   ssa_pkg::ssa_reg_t wr_sel;

   // address decode shared by read and write paths
   function automatic ssa_pkg::ssa_reg_t reg_decode(input logic [ssa_pkg::ADDR_W-1:0] addr);
      ssa_pkg::ssa_reg_t sel;
      sel = ssa_pkg::SSA_REG_NONE;
      if (addr == ssa_pkg::OFS_CTRL)
      begin
         sel = ssa_pkg::SSA_REG_CTRL;
      end
      else if (addr == ssa_pkg::OFS_STATUS)
      begin
         sel = ssa_pkg::SSA_REG_STATUS;
      end
      else if (addr == ssa_pkg::OFS_SHIFT)
      begin
         sel = ssa_pkg::SSA_REG_SHIFT;
      end
      return sel;
   endfunction

   // ************************************************************
   // pin capture
   // ************************************************************
   // every pin is asynchronous to clk_i, including the serial clock
   assign pins_raw[ssa_pkg::PIN_SCLK] = serial_clock_i;
   assign pins_raw[ssa_pkg::PIN_SDATA] = serial_data_i;
   assign pins_raw[ssa_pkg::PIN_STROBE] = latch_strobe_i;
   assign pins_raw[ssa_pkg::PIN_SEL] = parallel_serial_select_i;
   assign pins_raw[ssa_pkg::PIN_PAR_LSB +: ATTEN_W] = {atten_bit_sixteen_db_i, atten_bit_eight_db_i,
      atten_bit_four_db_i, atten_bit_two_db_i, atten_bit_one_db_i, atten_bit_half_db_i, atten_bit_quarter_db_i};

   ssa_sync #(
      .WIDTH(ssa_pkg::PIN_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   // named views of the settled pins
   assign s_sclk = pins_s[ssa_pkg::PIN_SCLK];
   assign s_sdata = pins_s[ssa_pkg::PIN_SDATA];
   assign s_strobe = pins_s[ssa_pkg::PIN_STROBE];
   assign s_sel = pins_s[ssa_pkg::PIN_SEL];
   assign s_par = pins_s[ssa_pkg::PIN_PAR_LSB +: ATTEN_W];

   // edges found against the previous settled sample
   assign ser_rise = s_sclk & ~r_q.sclk_prev;
   assign strobe_rise = s_strobe & ~r_q.strobe_prev;
   assign wr_sel = reg_decode(avs_address_i);

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb
   begin
      read_mux = '0;
      if (wr_sel == ssa_pkg::SSA_REG_CTRL)
      begin
         read_mux[ssa_pkg::CTRL_FREEZE_BIT] = r_q.freeze;
      end
      else if (wr_sel == ssa_pkg::SSA_REG_STATUS)
      begin
         read_mux[ssa_pkg::STAT_ATTEN_LSB +: ATTEN_W] = r_q.atten;
         read_mux[ssa_pkg::STAT_MODE_BIT] = s_sel;
         read_mux[ssa_pkg::STAT_STROBE_BIT] = s_strobe;
         read_mux[ssa_pkg::STAT_RUN_BIT] = (r_q.state == ssa_pkg::SSA_ST_RUN);
      end
      else if (wr_sel == ssa_pkg::SSA_REG_SHIFT)
      begin
         read_mux[WORD_W-1:0] = r_q.shift;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      r_d = r_q;
      r_d.sclk_prev = s_sclk;
      r_d.strobe_prev = s_strobe;
      // shift on clock rise
      // shifting runs in both modes so a word can be staged before switching
      if (ser_rise)
      begin
         r_d.shift = {r_q.shift[WORD_W-2:0], s_sdata};
      end
      case (r_q.state)
         ssa_pkg::SSA_ST_INIT:
         begin
            r_d.init_cnt = r_q.init_cnt + 2'h1;
            // adopt bus at turn-on
            // a high strobe here breaks the power-up contract, so maximum stays
            if (r_q.init_cnt == ssa_pkg::INIT_LAST)
            begin
               r_d.state = ssa_pkg::SSA_ST_RUN;
               if (!s_strobe)
               begin
                  r_d.atten = s_par;
               end
            end
         end
         ssa_pkg::SSA_ST_RUN:
         begin
            if (!r_q.freeze)
            begin
               if (s_sel)
               begin
                  if (strobe_rise)
                  begin
                     r_d.atten = r_q.shift[ATTEN_W-1:0];
                  end
               end
               else if (s_strobe)
               begin
                  r_d.atten = s_par;
               end
            end
         end
         default:
         begin
            r_d.state = ssa_pkg::SSA_ST_INIT;
         end
      endcase
      // bus slave: one wait cycle, then answer for exactly one cycle
      if (r_q.waitreq)
      begin
         if (avs_read_i || avs_write_i)
         begin
            r_d.waitreq = 1'b0;
            r_d.rdata = avs_read_i ? read_mux : '0;
         end
      end
      else
      begin
         r_d.waitreq = 1'b1;
         if (avs_write_i && wr_sel == ssa_pkg::SSA_REG_CTRL && avs_byteenable_i[0])
         begin
            r_d.freeze = avs_writedata_i[ssa_pkg::CTRL_FREEZE_BIT];
         end
      end
   end

   // reset loads maximum
   // reset stands for supply ramp; attenuation starts fully in
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_q.state <= ssa_pkg::SSA_ST_INIT;
         r_q.init_cnt <= '0;
         r_q.shift <= '0;
         r_q.atten <= ATTEN_FULL;
         r_q.sclk_prev <= 1'b0;
         r_q.strobe_prev <= 1'b0;
         r_q.freeze <= ssa_pkg::CTRL_FREEZE_RST;
         r_q.waitreq <= 1'b1;
         r_q.rdata <= '0;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // outputs straight from the state register
   assign atten_state_o = r_q.atten;
   assign avs_waitrequest_o = r_q.waitreq;
   assign avs_readdata_o = r_q.rdata;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking ssa_cb @(posedge clk_i);
   endclocking

   logic run;
   assign run = (r_q.state == ssa_pkg::SSA_ST_RUN) && !r_q.freeze;

   AST_SERIAL_IGNORES_BUS:
   assert property (disable iff (rst_i) (run && s_sel && !strobe_rise) [*2] |-> $stable(r_q.atten))
   else $error("attenuation moved in serial mode without a strobe rise");

   AST_DIRECT_FOLLOW:
   assert property (disable iff (rst_i) run && !s_sel && s_strobe |=> atten_state_o == $past(s_par))
   else $error("direct parallel mode did not follow the control bits");

   AST_RESET_MAX:
   assert property (rst_i ##1 rst_i |-> atten_state_o == ATTEN_FULL)
   else $error("attenuation not at maximum during reset");

   AST_INIT_ADOPT:
   assert property (disable iff (rst_i)
      r_q.state == ssa_pkg::SSA_ST_INIT && r_q.init_cnt == ssa_pkg::INIT_LAST && !s_strobe
      |=> atten_state_o == $past(s_par) && r_q.state == ssa_pkg::SSA_ST_RUN)
   else $error("power-up value from the parallel bits not adopted");

   AST_HOLD_NO_STROBE:
   assert property (disable iff (rst_i)
      r_q.state == ssa_pkg::SSA_ST_RUN && !strobe_rise && !(!s_sel && s_strobe && !r_q.freeze)
      |=> $stable(atten_state_o))
   else $error("attenuation changed without a strobe rise");

   AST_SERIAL_LOAD:
   assert property (disable iff (rst_i) run && s_sel && strobe_rise
      |=> atten_state_o == $past(r_q.shift[ATTEN_W-1:0]))
   else $error("serial word not loaded on strobe rise");

   AST_PARALLEL_LATCH:
   assert property (disable iff (rst_i) run && !s_sel && strobe_rise
      |=> atten_state_o == $past(s_par))
   else $error("parallel bits not captured at strobe rise");

   AST_SHIFT_IN:
   assert property (disable iff (rst_i) ser_rise
      |=> r_q.shift == {$past(r_q.shift[WORD_W-2:0]), $past(s_sdata)})
   else $error("serial shifter did not take the data bit");

   COV_SERIAL_LOAD: cover property (disable iff (rst_i) run && s_sel && strobe_rise);
   COV_DIRECT: cover property (disable iff (rst_i) run && !s_sel && s_strobe && s_par != r_q.atten);
   COV_INIT_ADOPT: cover property (disable iff (rst_i)
      r_q.state == ssa_pkg::SSA_ST_INIT && r_q.init_cnt == ssa_pkg::INIT_LAST && !s_strobe);
   COV_BUS_READ: cover property (disable iff (rst_i) avs_read_i && !avs_waitrequest_o);

endmodule

//--- testbench/ssa_host_model.sv
// host-side model driving the attenuator's serial and parallel control pins
`timescale 1ns/100ps
module ssa_host_model
(
   input wire logic clk_i,
   output logic sclk_o,
   output logic sdata_o,
   output logic strobe_o,
   output logic sel_o,
   output logic [6:0] par_o
);
   // ************************************************************
   // pin drivers
   // ************************************************************
   // serial clock parked low between frames, never free running
   initial
   begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      strobe_o = 1'b0;
      sel_o = 1'b0;
      par_o = 7'h00;
   end

   // levels change right after an edge; caller lets an edge pass between calls
   task automatic set_pins(input logic s, input logic st, input logic [6:0] p);
      sel_o <= s;
      strobe_o <= st;
      par_o <= p;
   endtask

   // half is cycles per clock phase, 4 gives the 400 ns period, more is a slow host
   task automatic shift_word(input logic [7:0] w, input int half);
      int i;
      // msb first, set up before rise
      for (i = 7; i >= 0; i--)
      begin
         sdata_o <= w[i];
         repeat (half) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (half) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      repeat (half) @(posedge clk_i);
      // released data line must not keep showing the last bit
      sdata_o <= ~w[0];
      @(posedge clk_i);
   endtask

   task automatic pulse_strobe();
      // rise only after last clock rise settled
      strobe_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      strobe_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

//--- testbench/ssa_ctrl_test.sv
// self-checking bench for the step attenuator control block
`timescale 1ns/100ps
module ssa_ctrl_test;
   logic clk_i;
   logic rst_i;
   logic sclk, sdata, strobe, sel;
   logic [6:0] par;
   logic [3:0] avs_address;
   logic avs_read, avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [6:0] atten;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;

   // ************************************************************
   // clock, instances, timeout
   // ************************************************************
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   ssa_host_model host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe),
      .sel_o(sel), .par_o(par));

   ssa_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sclk), .serial_data_i(sdata),
      .latch_strobe_i(strobe), .parallel_serial_select_i(sel), .atten_bit_quarter_db_i(par[0]),
      .atten_bit_half_db_i(par[1]), .atten_bit_one_db_i(par[2]), .atten_bit_two_db_i(par[3]),
      .atten_bit_four_db_i(par[4]), .atten_bit_eight_db_i(par[5]), .atten_bit_sixteen_db_i(par[6]),
      .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
      .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .atten_state_o(atten));

   // whole run needs about 1300 cycles, so 20000 means a hang
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         end_sim();
      end
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e)
      begin
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
         failures++;
      end
   endtask

   task automatic chk_att(input logic [6:0] e, input string m);
      chk({25'h0, atten}, {25'h0, e}, m);
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus_go(input logic [3:0] a, input logic rd, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] rdat);
      @(posedge clk_i);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= wd;
      avs_byteenable <= be;
      // no local limit: a stuck slave is caught by the cycle timeout
      do
      begin
         @(posedge clk_i);
      end
      while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string m);
      logic [31:0] d;
      bus_go(a, 1'b1, 32'h00000000, 4'hF, d);
      chk(d, e, m);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      logic [7:0] w;
      logic [6:0] prev;
      logic [31:0] d;
      int i;
      rst_i <= 1'b1;
      avs_address <= 4'h0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h00000000;
      avs_byteenable <= 4'hF;
      // serial mode, strobe high: no adopt at init and no direct follow after it
      host.set_pins(1'b1, 1'b1, 7'h15);
      repeat (10) @(posedge clk_i);
      chk_att(7'h7F, "reset value");
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_att(7'h7F, "default power-up");
      rst_i <= 1'b1;
      host.set_pins(1'b0, 1'b0, 7'h2A);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_att(7'h2A, "adopted power-up");
      rd_chk(ssa_pkg::OFS_STATUS, 32'h0000042A, "status parallel");
      // latched parallel, one weight at a time
      prev = 7'h2A;
      for (i = 0; i < 7; i++)
      begin
         host.set_pins(1'b0, 1'b0, 7'h01 << i);
         repeat (6) @(posedge clk_i);
         chk_att(prev, "held between strobes");
         host.set_pins(1'b0, 1'b1, 7'h01 << i);
         repeat (6) @(posedge clk_i);
         chk_att(7'h01 << i, "latched weight");
         prev = 7'h01 << i;
      end
      host.set_pins(1'b0, 1'b1, 7'h33);
      repeat (6) @(posedge clk_i);
      chk_att(7'h33, "direct follow");
      host.set_pins(1'b0, 1'b1, 7'h4C);
      repeat (6) @(posedge clk_i);
      chk_att(7'h4C, "direct change");
      host.set_pins(1'b1, 1'b0, 7'h7F);
      repeat (6) @(posedge clk_i);
      chk_att(7'h4C, "serial ignores bits");
      // serial words, top bit toggled to show it is ignored
      prev = 7'h4C;
      for (i = 0; i < 8; i++)
      begin
         w = (i == 7) ? 8'hFF : ((i % 2 == 0) ? 8'h80 : 8'h00) | (8'h01 << i);
         host.shift_word(w, 4);
         chk_att(prev, "held before strobe");
         rd_chk(ssa_pkg::OFS_SHIFT, {24'h000000, w}, "shifter");
         host.pulse_strobe();
         chk_att(w[6:0], "serial word");
         prev = w[6:0];
      end
      // slow host, earlier word must shift out
      host.shift_word(8'hFF, 10);
      host.shift_word(8'h05, 10);
      host.pulse_strobe();
      chk_att(7'h05, "newest eight bits");
      // freeze blocks pin loads; partial byteenable write ignored
      bus_go(ssa_pkg::OFS_CTRL, 1'b0, 32'h00000001, 4'hF, d);
      rd_chk(ssa_pkg::OFS_CTRL, 32'h00000001, "freeze set");
      host.shift_word(8'h11, 4);
      host.pulse_strobe();
      chk_att(7'h05, "frozen");
      bus_go(ssa_pkg::OFS_CTRL, 1'b0, 32'h00000000, 4'hE, d);
      rd_chk(ssa_pkg::OFS_CTRL, 32'h00000001, "byteenable ignored");
      bus_go(ssa_pkg::OFS_CTRL, 1'b0, 32'h00000000, 4'h1, d);
      host.pulse_strobe();
      chk_att(7'h11, "unfrozen load");
      rd_chk(ssa_pkg::OFS_STATUS, 32'h00000511, "status serial");
      bus_go(4'hC, 1'b0, 32'hFFFFFFFF, 4'hF, d);
      rd_chk(4'hC, 32'h00000000, "unmapped");
      end_sim();
   end
endmodule
